// [core/tfr_temp_fault.v]
// temperature fault response registers with a management-link slave and retry control
`timescale 1ns/100ps
`include "tfr_defines.vh"
module tfr_temp_fault #(
  parameter [6:0]  DEV_ADDR    = `TFR_DEV_ADDR,
  parameter [19:0] STEP_CYCLES = `TFR_RETRY_STEP_MS * `TFR_CLK_KHZ
) (
  input  wire        clk_i,
  input  wire        rst_i,
  input  wire        ce_i,
  input  wire        scl_i,
  input  wire        sda_i,
  output reg         sda_o,
  output reg         sda_oe_o,
  output reg         alert_line_o,
  output reg         alert_line_oe_o,
  input  wire [15:0] temp_i,
  input  wire        out_cmd_on_i,
  output reg         out_en_o,
  output reg  [7:0]  temp_status_o
);
  localparam [2:0] RS_RUN  = 3'b001, RS_WAIT = 3'b010, RS_HOLD = 3'b100;
  localparam [6:0] LS_IDLE = 7'b0000001, LS_ADDR = 7'b0000010, LS_CMD  = 7'b0000100,
                   LS_WDAT = 7'b0001000, LS_ACK  = 7'b0010000, LS_RDAT = 7'b0100000,
                   LS_RACK = 7'b1000000;
  // linear format to fixed point: 11-bit signed mantissa times two to a 5-bit signed exponent
  function signed [47:0] lin2fix;
    input [15:0] v;
    reg signed [47:0] m;
    begin
      m = {{37{v[10]}}, v[10:0]};
      lin2fix = m <<< ({1'b0, v[15:11]} ^ 6'h10);
    end
  endfunction
  //////////////////////////////////////////////////////////////////////////////////////////
  // pin synchronisers and edge detection
  reg [1:0] scl_sq;
  reg [1:0] sda_sq;
  reg       scl_prev_q;
  reg       sda_prev_q;
  always @(posedge clk_i) begin
    if (rst_i) begin
      scl_sq     <= 2'h3;
      sda_sq     <= 2'h3;
      scl_prev_q <= 1'b1;
      sda_prev_q <= 1'b1;
    end else if (ce_i) begin
      scl_sq     <= {scl_sq[0], scl_i};
      sda_sq     <= {sda_sq[0], sda_i};
      scl_prev_q <= scl_sq[1];
      sda_prev_q <= sda_sq[1];
    end
  end
  wire scl_rise = scl_sq[1] & ~scl_prev_q;
  wire scl_fall = ~scl_sq[1] & scl_prev_q;
  wire bus_start = scl_sq[1] & scl_prev_q & ~sda_sq[1] & sda_prev_q;
  wire bus_stop  = scl_sq[1] & scl_prev_q & sda_sq[1] & ~sda_prev_q;
  //////////////////////////////////////////////////////////////////////////////////////////
  // registers and temperature comparison
  reg  [7:0]  action_q;
  reg  [15:0] ot_fault_thr_q;
  reg  [15:0] ot_warn_thr_q;
  reg  [15:0] ut_warn_thr_q;
  reg  [7:0]  wr_lo_q;
  reg  [7:0]  st_clr;
  reg         wr_stb;
  reg  [15:0] wr_val;
  wire signed [47:0] temp_fix = lin2fix(temp_i);
  wire ot_fault = temp_fix > lin2fix(ot_fault_thr_q);
  wire ot_warn  = temp_fix > lin2fix(ot_warn_thr_q);
  wire ut_warn  = temp_fix < lin2fix(ut_warn_thr_q);
  wire [1:0] resp_code = action_q[`TFR_ACT_RESP_HI:`TFR_ACT_RESP_LO];
  wire [2:0] try_max   = action_q[`TFR_ACT_TRY_HI:`TFR_ACT_TRY_LO];
  wire [2:0] dly_steps = action_q[`TFR_ACT_DLY_HI:`TFR_ACT_DLY_LO];
  //////////////////////////////////////////////////////////////////////////////////////////
  // management link slave: byte and word reads and writes, low byte first
  reg [6:0] ls_q;
  reg [3:0] bit_q;
  reg [7:0] sh_q;
  reg [7:0] cmd_q;
  reg       byte_q;
  reg       rd_q;
  reg       to_cmd_q;
  reg [7:0] tx_q;
  wire is_word = (cmd_q == `TFR_CMD_OT_FAULT_THR) | (cmd_q == `TFR_CMD_OT_WARN_THR) |
                 (cmd_q == `TFR_CMD_UT_WARN_THR);
  reg [15:0] rd_word;
  always @* begin
    case (cmd_q)
      `TFR_CMD_OT_FAULT_THR: rd_word = ot_fault_thr_q;
      `TFR_CMD_OT_ACTION:    rd_word = {`TFR_RST_BYTE, action_q};
      `TFR_CMD_OT_WARN_THR:  rd_word = ot_warn_thr_q;
      `TFR_CMD_UT_WARN_THR:  rd_word = ut_warn_thr_q;
      `TFR_CMD_TEMP_STATUS:  rd_word = {`TFR_RST_BYTE, temp_status_o};
      default:               rd_word = {`TFR_RST_BYTE, `TFR_RST_BYTE};
    endcase
  end
  wire [7:0] rd_byte = byte_q ? rd_word[15:8] : rd_word[7:0];
  always @(posedge clk_i) begin
    if (rst_i) begin
      ls_q     <= LS_IDLE;
      bit_q    <= 4'h0;
      sh_q     <= 8'h00;
      cmd_q    <= 8'h00;
      byte_q   <= 1'b0;
      rd_q     <= 1'b0;
      to_cmd_q <= 1'b0;
      tx_q     <= 8'h00;
      wr_lo_q  <= 8'h00;
      sda_o    <= 1'b0;
      sda_oe_o <= 1'b0;
    end else if (ce_i) begin
      sda_o <= 1'b0;
      if (bus_start) begin
        ls_q     <= LS_ADDR;
        bit_q    <= 4'h0;
        byte_q   <= 1'b0;
        sda_oe_o <= 1'b0;
      end else if (bus_stop) begin
        ls_q     <= LS_IDLE;
        sda_oe_o <= 1'b0;
      end else if (scl_rise) begin
        if (ls_q == LS_ADDR || ls_q == LS_CMD || ls_q == LS_WDAT) begin
          sh_q  <= {sh_q[6:0], sda_sq[1]};
          bit_q <= bit_q + 4'h1;
        end else if (ls_q == LS_RDAT) begin
          bit_q <= bit_q + 4'h1;
        end else if (ls_q == LS_RACK && sda_sq[1]) begin
          ls_q <= LS_IDLE; // master ended the read
        end
      end else if (scl_fall) begin
        case (ls_q)
          LS_ADDR: if (bit_q == 4'h8) begin
            if (sh_q[7:1] == DEV_ADDR) begin
              rd_q     <= sh_q[0];
              to_cmd_q <= ~sh_q[0];
              ls_q     <= LS_ACK;
              sda_oe_o <= 1'b1;
            end else begin
              ls_q <= LS_IDLE;
            end
          end
          LS_CMD: if (bit_q == 4'h8) begin
            cmd_q    <= sh_q;
            ls_q     <= LS_ACK;
            sda_oe_o <= 1'b1;
          end
          LS_WDAT: if (bit_q == 4'h8) begin
            wr_lo_q  <= sh_q;
            byte_q   <= 1'b1;
            ls_q     <= LS_ACK;
            sda_oe_o <= 1'b1;
          end
          LS_ACK, LS_RACK: begin
            bit_q <= 4'h0;
            if (rd_q) begin
              ls_q     <= LS_RDAT;
              tx_q     <= {rd_byte[6:0], 1'b0};
              sda_oe_o <= ~rd_byte[7];
            end else begin
              ls_q     <= to_cmd_q ? LS_CMD : LS_WDAT;
              to_cmd_q <= 1'b0;
              sda_oe_o <= 1'b0;
            end
          end
          LS_RDAT: begin
            if (bit_q == 4'h8) begin
              ls_q     <= LS_RACK;
              sda_oe_o <= 1'b0;
              byte_q   <= ~byte_q;
            end else begin
              tx_q     <= {tx_q[6:0], 1'b0};
              sda_oe_o <= ~tx_q[7];
            end
          end
          default: ls_q <= ls_q;
        endcase
      end
    end
  end
  // a write lands when its last byte is in: byte commands on the first, words on the second
  always @* begin
    wr_stb = ce_i & scl_fall & (ls_q == LS_WDAT) & (bit_q == 4'h8) & (byte_q | ~is_word);
    wr_val = byte_q ? {sh_q, wr_lo_q} : {`TFR_RST_BYTE, sh_q};
    st_clr = (wr_stb && cmd_q == `TFR_CMD_TEMP_STATUS) ? sh_q : 8'h00;
  end
  always @(posedge clk_i) begin
    if (rst_i) begin
      action_q       <= `TFR_RST_ACTION;
      ot_fault_thr_q <= `TFR_RST_OT_FAULT_THR;
      ot_warn_thr_q  <= `TFR_RST_OT_WARN_THR;
      ut_warn_thr_q  <= `TFR_RST_UT_WARN_THR;
    end else if (wr_stb) begin
      case (cmd_q)
        `TFR_CMD_OT_FAULT_THR: ot_fault_thr_q <= wr_val;
        `TFR_CMD_OT_ACTION:    action_q       <= wr_val[7:0];
        `TFR_CMD_OT_WARN_THR:  ot_warn_thr_q  <= wr_val;
        `TFR_CMD_UT_WARN_THR:  ut_warn_thr_q  <= wr_val;
        default:               action_q       <= action_q;
      endcase
    end
  end
  //////////////////////////////////////////////////////////////////////////////////////////
  // status, alert and retry control
  reg [2:0]  rs_q;
  reg [2:0]  tries_q;
  reg [2:0]  step_q;
  reg [19:0] cyc_q;
  always @(posedge clk_i) begin
    if (rst_i) begin
      temp_status_o   <= 8'h00;
      alert_line_o    <= 1'b0;
      alert_line_oe_o <= 1'b0;
    end else if (ce_i) begin
      // a new event beats a clear in the same cycle
      temp_status_o[`TFR_ST_OT_FAULT] <= ot_fault |
        (temp_status_o[`TFR_ST_OT_FAULT] & ~st_clr[`TFR_ST_OT_FAULT]);
      temp_status_o[`TFR_ST_OT_WARN] <= ot_warn |
        (temp_status_o[`TFR_ST_OT_WARN] & ~st_clr[`TFR_ST_OT_WARN]);
      temp_status_o[`TFR_ST_UT_WARN] <= ut_warn |
        (temp_status_o[`TFR_ST_UT_WARN] & ~st_clr[`TFR_ST_UT_WARN]);
      alert_line_oe_o <= ot_fault | ot_warn | ut_warn | (|(temp_status_o & ~st_clr));
    end
  end
  always @(posedge clk_i) begin
    if (rst_i) begin
      rs_q     <= RS_RUN;
      tries_q  <= 3'h0;
      step_q   <= 3'h0;
      cyc_q    <= 20'h00000;
      out_en_o <= 1'b0;
    end else if (ce_i) begin
      case (rs_q)
        RS_RUN: begin
          out_en_o <= out_cmd_on_i;
          if (~temp_status_o[`TFR_ST_OT_FAULT] | ~out_cmd_on_i)
            tries_q <= 3'h0;
          if (out_cmd_on_i & ot_fault & (resp_code == `TFR_RESP_LATCH)) begin
            out_en_o <= 1'b0;
            rs_q     <= RS_HOLD;
          end else if (out_cmd_on_i & ot_fault & (resp_code == `TFR_RESP_RETRY)) begin
            out_en_o <= 1'b0;
            cyc_q    <= 20'h00000;
            step_q   <= 3'h0;
            if (try_max == `TFR_TRY_NONE)
              rs_q <= RS_HOLD;
            else if (try_max != `TFR_TRY_FOREVER && tries_q == try_max)
              rs_q <= RS_HOLD;
            else begin
              rs_q    <= RS_WAIT;
              tries_q <= (try_max == `TFR_TRY_FOREVER) ? tries_q : tries_q + 3'h1;
            end
          end
        end
        RS_WAIT: begin
          if (~out_cmd_on_i) begin
            rs_q    <= RS_RUN;
            tries_q <= 3'h0;
          end else if (cyc_q == STEP_CYCLES - 20'h00001) begin
            cyc_q <= 20'h00000;
            if (step_q == dly_steps) begin
              rs_q     <= RS_RUN;
              out_en_o <= 1'b1;
            end else begin
              step_q <= step_q + 3'h1;
            end
          end else begin
            cyc_q <= cyc_q + 20'h00001;
          end
        end
        RS_HOLD: begin
          // stays off until the host clears the fault and the temperature is back under limit
          if (~temp_status_o[`TFR_ST_OT_FAULT] & ~ot_fault) begin
            rs_q    <= RS_RUN;
            tries_q <= 3'h0;
          end
        end
        default: rs_q <= RS_RUN;
      endcase
    end
  end
endmodule

// [pkg/tfr_defines.vh]
// register offsets, field layout, reset values and timing for the temperature fault response
`ifndef TFR_DEFINES_VH
`define TFR_DEFINES_VH
`define TFR_CMD_OT_FAULT_THR   8'h4F
`define TFR_CMD_OT_ACTION      8'h50
`define TFR_CMD_OT_WARN_THR    8'h51
`define TFR_CMD_UT_WARN_THR    8'h52
`define TFR_CMD_TEMP_STATUS    8'h7D
`define TFR_ACT_RESP_HI        7
`define TFR_ACT_RESP_LO        6
`define TFR_ACT_TRY_HI         5
`define TFR_ACT_TRY_LO         3
`define TFR_ACT_DLY_HI         2
`define TFR_ACT_DLY_LO         0
`define TFR_RESP_RETRY         2'h2
`define TFR_RESP_LATCH         2'h3
`define TFR_TRY_NONE           3'h0
`define TFR_TRY_FOREVER        3'h7
`define TFR_ST_OT_FAULT        7
`define TFR_ST_OT_WARN         6
`define TFR_ST_UT_WARN         5
`define TFR_RST_ACTION         8'hBF
`define TFR_RST_OT_FAULT_THR   16'h0FD4
`define TFR_RST_OT_WARN_THR    16'h0FAA
`define TFR_RST_UT_WARN_THR    16'hE580
`define TFR_RST_BYTE           8'h00
`define TFR_DEV_ADDR           7'h24
`define TFR_RETRY_STEP_MS      35
`define TFR_CLK_KHZ            25000
`endif

// [tb/tfr_chk.sv]
// concurrent checks on the temperature fault response ports
`timescale 1ns/100ps
module tfr_chk #(
  parameter [19:0] STEP_CYCLES = 20'h14
) (
  input wire       clk_i,
  input wire       rst_i,
  input wire       ce_i,
  input wire       scl_i,
  input wire       sda_o,
  input wire       sda_oe_o,
  input wire       alert_line_o,
  input wire       alert_line_oe_o,
  input wire       out_cmd_on_i,
  input wire       out_en_o,
  input wire [7:0] temp_status_o
);
  reg [23:0] off_q;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // off time while commanded on; a restart sooner than one step is early
  always @(posedge clk_i)
    if (rst_i || !out_cmd_on_i || out_en_o) off_q <= 24'h000000;
    else if (ce_i) off_q <= off_q + 24'h000001;
  ////////////////////////////////////////////////////////////
  property p_rst; disable iff (1'b0)
    rst_i |=> !out_en_o && !alert_line_oe_o && !sda_oe_o && temp_status_o == 8'h00; endproperty
  a_rst: assert property (p_rst) else $error("outputs not cleared by reset");
  property p_pins; sda_o == 1'b0 && alert_line_o == 1'b0; endproperty
  a_pins: assert property (p_pins) else $error("open drain pin driven high");
  // alert follows the status byte in the same cycle, so a clear drops both together
  property p_alert; alert_line_oe_o == (temp_status_o != 8'h00); endproperty
  a_alert: assert property (p_alert) else $error("alert not raised for status");
  property p_cmd_off; ce_i && !out_cmd_on_i |=> !out_en_o; endproperty
  a_cmd_off: assert property (p_cmd_off) else $error("output on while commanded off");
  property p_cmd_gate; $rose(out_en_o) |-> $past(out_cmd_on_i); endproperty
  a_cmd_gate: assert property (p_cmd_gate) else $error("output started without command");
  property p_gap;
    $rose(out_en_o) && $past(temp_status_o[7]) && off_q > 2 |-> off_q + 3 >= STEP_CYCLES;
  endproperty
  a_gap: assert property (p_gap) else $error("restart before retry delay");
  property p_freeze; !ce_i |=> $stable(out_en_o) && $stable(temp_status_o); endproperty
  a_freeze: assert property (p_freeze) else $error("state moved with enable low");
  property p_ack; $rose(sda_oe_o) |-> !scl_i; endproperty
  a_ack: assert property (p_ack) else $error("data driven while clock high");
  c_off: cover property ($fell(out_en_o) && out_cmd_on_i);
  c_restart: cover property ($rose(out_en_o) && off_q > 2);
  c_alert: cover property ($rose(alert_line_oe_o));
endmodule

// [tb/tfr_host.sv]
// management link host model with push-pull clock and open-drain data
`timescale 1ns/100ps
module tfr_host #(
  parameter [6:0] ADDR = 7'h24
) (
  output reg  scl_o,
  output reg  sda_low_o,
  input  wire sda_i
);
  integer nacks = 0;
  initial begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
  end
  // 240 ns low with data moved mid-way leaves three clocks either side of each edge
  task xfer(input logic b, output logic s);
    scl_o = 1'b0;
    #120 sda_low_o = !b;
    #120 scl_o = 1'b1;
    #40 s = sda_i;
    #40;
  endtask
  task start(input logic sr);
    if (sr) begin
      scl_o = 1'b0;
      #120 sda_low_o = 1'b0;
      #120 scl_o = 1'b1;
      #120;
    end
    sda_low_o = 1'b1;
    #120;
  endtask
  task stop;
    scl_o = 1'b0;
    #120 sda_low_o = 1'b1;
    #120 scl_o = 1'b1;
    #120 sda_low_o = 1'b0;
    #120;
  endtask
  task byte_io(input [7:0] tx, input logic last, input logic chk, output [7:0] rx);
    logic a;
    for (int i = 7; i >= 0; i--) xfer(tx[i], rx[i]);
    xfer(last, a);
    if (chk && a) nacks = nacks + 1;
  endtask
  task write(input [7:0] cmd, input [15:0] d, input int n);
    logic [7:0] rx;
    start(1'b0);
    byte_io({ADDR, 1'b0}, 1'b1, 1'b1, rx);
    byte_io(cmd, 1'b1, 1'b1, rx);
    for (int i = 0; i < n; i++) byte_io(d[8*i +: 8], 1'b1, 1'b1, rx);
    stop;
  endtask
  task read(input [7:0] cmd, input int n, output [15:0] d);
    logic [7:0] rx;
    d = 16'h0000;
    start(1'b0);
    byte_io({ADDR, 1'b0}, 1'b1, 1'b1, rx);
    byte_io(cmd, 1'b1, 1'b1, rx);
    start(1'b1);
    byte_io({ADDR, 1'b1}, 1'b1, 1'b1, rx);
    for (int i = 0; i < n; i++) begin
      byte_io(8'hFF, i == n - 1, 1'b0, rx);
      d[8*i +: 8] = rx;
    end
    stop;
  endtask
endmodule

// [tb/tfr_temp_fault_tb.sv]
// self-checking bench for the temperature fault response block
`timescale 1ns/100ps
module tfr_temp_fault_tb;
  localparam [19:0] STEP = 20'h14;
  reg         clk_i = 1'b0, rst_i = 1'b1, ce_i = 1'b1, out_cmd_on_i = 1'b0, prev;
  reg  [15:0] temp_i = 16'h0020, d, w;
  reg  [31:0] seed = 32'hED13;
  reg  [7:0]  act;
  // {response, retry count}: report, report, hold, retry none, two, forever
  reg  [4:0]  cases [0:5] = '{5'h00, 5'h0F, 5'h1A, 5'h10, 5'h12, 5'h17};
  wire        scl, h_low, sda_o, sda_oe_o, alert_line_o, alert_line_oe_o, out_en_o;
  wire [7:0]  temp_status_o;
  wire        sda = !(h_low || sda_oe_o);
  integer     fails = 0, check_count = 0, cyc = 0, rises, first, gap;
  tfr_temp_fault #(.STEP_CYCLES(STEP)) tfr_temp_fault_inst (.clk_i(clk_i), .rst_i(rst_i),
    .ce_i(ce_i), .scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
    .alert_line_o(alert_line_o), .alert_line_oe_o(alert_line_oe_o), .temp_i(temp_i),
    .out_cmd_on_i(out_cmd_on_i), .out_en_o(out_en_o), .temp_status_o(temp_status_o));
  tfr_host #(.ADDR(7'h24)) tfr_host_inst (.scl_o(scl), .sda_low_o(h_low), .sda_i(sda));
  always #20 clk_i = ~clk_i;
  ////////////////////////////////////////////////////////////
  function [31:0] lfsr(input [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // restarts seen in nine retry delays, capped at seven
  function integer exp_rises(input [4:0] c);
    exp_rises = (c[4:3] != 2'b10) ? 0 : c[2:0];
  endfunction
  task check(input [15:0] seen, input [15:0] exp);
    check_count = check_count + 1;
    if (seen !== exp) begin
      fails = fails + 1;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task end_of_test;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  always @(posedge clk_i) begin
    cyc = cyc + 1;
    if (cyc == 60000) begin
      fails = fails + 1;
      end_of_test;
    end
  end
  ////////////////////////////////////////////////////////////
  initial begin
    tick(16);
    rst_i = 1'b0;
    tick(4);
    tfr_host_inst.read(8'h50, 1, d);
    check(d, 16'h00BF);
    tfr_host_inst.read(8'h51, 2, d);
    check(d, 16'h0FAA);
    tfr_host_inst.read(8'h52, 2, d);
    check(d, 16'hE580);
    for (int i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      w = seed[15:0];
      tfr_host_inst.write(8'h51 + i[0], w, 2);
      tfr_host_inst.read(8'h51 + i[0], 2, d);
      check(d, w);
    end
    // a word command cut short after one byte must leave the register alone
    tfr_host_inst.write(8'h51, 16'h0050, 2);
    tfr_host_inst.write(8'h51, 16'h0033, 1);
    tfr_host_inst.read(8'h51, 2, d);
    check(d, 16'h0050);
    tfr_host_inst.write(8'h52, 16'h0005, 2);
    tfr_host_inst.write(8'h4F, 16'h0064, 2);
    tfr_host_inst.read(8'h4F, 2, d);
    check(d, 16'h0064);
    tfr_host_inst.write(8'h7D, 16'h00FF, 1);
    ce_i = 1'b0;
    out_cmd_on_i = 1'b1;
    tick(5);
    check(out_en_o, 1'b0);
    ce_i = 1'b1;
    tick(2);
    check({out_en_o, temp_status_o}, 9'h100);
    temp_i = 16'h005A;
    tick(3);
    check(temp_status_o, 8'h40);
    temp_i = 16'h0002;
    tick(3);
    check({alert_line_oe_o, out_en_o, temp_status_o}, 10'h360);
    tfr_host_inst.read(8'h7D, 1, d);
    check(d, 16'h0060);
    for (int k = 0; k < 6; k++) begin
      temp_i = 16'h0020;
      tfr_host_inst.write(8'h7D, 16'h00FF, 1);
      tick(2);
      check(alert_line_oe_o, 1'b0);
      seed = lfsr(seed);
      act = {cases[k], seed[2:0]};
      gap = (act[2:0] + 1) * STEP;
      tfr_host_inst.write(8'h50, {8'h00, act}, 1);
      tfr_host_inst.read(8'h50, 1, d);
      check(d, {8'h00, act});
      temp_i = 16'h0070;
      tick(1);
      check(out_en_o, !act[7]);
      rises = 0;
      first = 0;
      prev = out_en_o;
      for (int i = 0; i < 9 * gap; i++) begin
        tick(1);
        if (out_en_o && !prev) begin
          rises = rises + 1;
          if (rises == 1) first = i;
        end
        prev = out_en_o;
      end
      check(rises > 7 ? 7 : rises, exp_rises(cases[k]));
      if (rises > 0) check(first + 3 >= gap && first <= gap, 1'b1);
      check({temp_status_o[7], alert_line_oe_o}, 2'b11);
      temp_i = 16'h0020;
      tfr_host_inst.write(8'h7D, 16'h00FF, 1);
      tick(3);
      check({out_en_o, temp_status_o}, 9'h100);
    end
    check(tfr_host_inst.nacks, 0);
    end_of_test;
  end
endmodule
bind tfr_temp_fault tfr_chk #(.STEP_CYCLES(STEP_CYCLES)) tfr_chk_inst (.clk_i(clk_i),
  .rst_i(rst_i), .ce_i(ce_i), .scl_i(scl_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
  .alert_line_o(alert_line_o), .alert_line_oe_o(alert_line_oe_o),
  .out_cmd_on_i(out_cmd_on_i), .out_en_o(out_en_o), .temp_status_o(temp_status_o));
